// ### rtl/cbwd_decode.sv
// configuration registers, window decode and latency timer of the card bridge
//
// Operation
// R1: secondary bus number register, used in configuration forwarding decision
// R2: subordinate bus number register, upper bound for configuration forwarding
// R3: latency timer loads on initiator frame start, counts link clock cycles
// R4: on expiry, initiated transaction ends at the next completed data phase
// R5: host should program latency at least 20h
// R6: memory base and limit bits 31-12 writable, 4 KB granularity
// R7: memory base and limit bits 11-0 read zero, writes ignored
// R8: memory windows claim primary cycles and steer secondary cycles upstream
// R9: memory window with base and limit both zero claims nothing
// R10: window 0 and 1 prefetchability follow bridge control bits 8 and 9
// R11: io base upper half reads zero, window confined to first 64 KB page
// R12: io base writable from bit 2, doubleword aligned
// R13: io base low two bits read 00b or 01b by base select
// R14: io limit bits 15-2 writable, bits 31-16 read zero
// R15: io limit low two bits read 00b or 01b by limit select
// R16: writes to read-only io limit bits leave values unchanged
// R17: io window with base and limit both zero forwards nothing
// R18: io windows claim primary cycles and steer secondary cycles upstream
// R19: primary bus number register, reset zero, third forwarding input
// R20: hit means base <= address <= limit with low bits filled
// R21: bus above secondary up to subordinate goes beyond; equal goes to secondary
`timescale 1ns/1ps

module cbwd_decode #(
  parameter int CCLK_DIV = cbwd_pkg::CCLK_DIV
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // configuration access port
  input  wire cbwd_pkg::cbwd_cfg_type cfg,
  output logic [31:0]                cfg_rdata,
  output logic                       cfg_rvalid,
  // control bits held elsewhere in the bridge
  input  wire logic                  mem_window0_prefetchable,
  input  wire logic                  mem_window1_prefetchable,
  input  wire logic                  io_base_sel,
  input  wire logic                  io_limit_sel,
  // configuration cycle routing
  input  wire logic                  cfg_cycle_valid,
  input  wire logic [7:0]            cfg_cycle_bus,
  output logic                       cfg_to_primary,
  output logic                       cfg_to_secondary,
  output logic                       cfg_beyond_secondary,
  // primary-side claim
  input  wire cbwd_pkg::cbwd_req_type pri_req,
  output logic                       pri_claim,
  output logic                       pri_prefetch,
  output logic [1:0]                 pri_window_hit,
  // secondary-side upstream forward
  input  wire cbwd_pkg::cbwd_req_type sec_req,
  output logic                       sec_forward,
  // initiator latency timer
  input  wire logic                  init_frame_start,
  input  wire logic                  init_data_done,
  input  wire logic                  init_xfer_end,
  output logic                       lat_expired,
  output logic                       init_last_phase
);

  // configuration state
  logic [7:0]  primary_bus_q;
  logic [7:0]  secondary_bus_q;
  logic [7:0]  subordinate_bus_q;
  logic [7:0]  latency_q;
  logic [19:0] mem_base_q  [2];
  logic [19:0] mem_limit_q [2];
  logic [13:0] io_base_q   [2];
  logic [13:0] io_limit_q  [2];

  // merge byte lanes of a configuration write into an old word
  function automatic logic [31:0] merge_be(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return res;
  endfunction : merge_be

  // readback word for a memory register: low field always zero
  function automatic logic [31:0] mem_word(input logic [19:0] f);
    return {f, 12'h000}; // R7
  endfunction : mem_word

  // readback word for an io register: page zero, low bits from select
  function automatic logic [31:0] io_word(input logic [13:0] f, input logic sel);
    return {16'h0000, f, sel ? cbwd_pkg::IO_LOW_SEL_SET : cbwd_pkg::IO_LOW_SEL_CLR}; // R11 R13 R15
  endfunction : io_word

  logic [7:0] dw_addr;
  logic       wr_bus_dw;
  logic [31:0] bus_dw_old;
  logic [31:0] bus_dw_new;

  assign dw_addr    = {cfg.addr[7:2], 2'b00};
  assign wr_bus_dw  = cfg.wr && (dw_addr == cbwd_pkg::OFF_PRIMARY_BUS);
  assign bus_dw_old = {latency_q, subordinate_bus_q, secondary_bus_q, primary_bus_q};
  assign bus_dw_new = merge_be(bus_dw_old, cfg.wdata, cfg.be);

  // bus numbers and latency share one doubleword, one byte lane each
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      primary_bus_q     <= cbwd_pkg::RST_BUS_NUMBER; // R19
      secondary_bus_q   <= cbwd_pkg::RST_BUS_NUMBER;
      subordinate_bus_q <= cbwd_pkg::RST_BUS_NUMBER;
      latency_q         <= cbwd_pkg::RST_LATENCY;
    end else if (wr_bus_dw) begin
      primary_bus_q     <= bus_dw_new[7:0];   // R19
      secondary_bus_q   <= bus_dw_new[15:8];  // R1
      subordinate_bus_q <= bus_dw_new[23:16]; // R2
      latency_q         <= bus_dw_new[31:24]; // R3
    end
  end

  // readback words of the window registers, the old word under a partial write
  logic [31:0] mem_base_rd   [2];
  logic [31:0] mem_limit_rd  [2];
  logic [31:0] io_base_rd    [2];
  logic [31:0] io_limit_rd   [2];
  // the same words with the lanes of the current write merged in
  logic [31:0] mem_base_wr   [2];
  logic [31:0] mem_limit_wr  [2];
  logic [31:0] io_base_wr    [2];
  logic [31:0] io_limit_wr   [2];
  // register selects; the two windows of a kind sit one stride apart
  logic [1:0]  sel_mem_base;
  logic [1:0]  sel_mem_limit;
  logic [1:0]  sel_io_base;
  logic [1:0]  sel_io_limit;

  // readback, merge and select for both windows
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      mem_base_rd[i]   = mem_word(mem_base_q[i]);              // R7
      mem_limit_rd[i]  = mem_word(mem_limit_q[i]);             // R7
      io_base_rd[i]    = io_word(io_base_q[i], io_base_sel);   // R13
      io_limit_rd[i]   = io_word(io_limit_q[i], io_limit_sel); // R15
      mem_base_wr[i]   = merge_be(mem_base_rd[i], cfg.wdata, cfg.be);
      mem_limit_wr[i]  = merge_be(mem_limit_rd[i], cfg.wdata, cfg.be);
      io_base_wr[i]    = merge_be(io_base_rd[i], cfg.wdata, cfg.be);
      io_limit_wr[i]   = merge_be(io_limit_rd[i], cfg.wdata, cfg.be);
      sel_mem_base[i]  = dw_addr == cbwd_pkg::OFF_MEM_WIN0_BASE + 8'(i) * cbwd_pkg::OFF_WIN_STRIDE;
      sel_mem_limit[i] = dw_addr == cbwd_pkg::OFF_MEM_WIN0_LIMIT + 8'(i) * cbwd_pkg::OFF_WIN_STRIDE;
      sel_io_base[i]   = dw_addr == cbwd_pkg::OFF_IO_WIN0_BASE + 8'(i) * cbwd_pkg::OFF_WIN_STRIDE;
      sel_io_limit[i]  = dw_addr == cbwd_pkg::OFF_IO_WIN0_LIMIT + 8'(i) * cbwd_pkg::OFF_WIN_STRIDE;
    end
  end

  // memory bases; only bits 31-12 are stored, so the low field cannot change
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        mem_base_q[i] <= cbwd_pkg::RST_MEM_FIELD;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cfg.wr && sel_mem_base[i]) begin
          mem_base_q[i] <= mem_base_wr[i][31:cbwd_pkg::MEM_ADDR_LSB]; // R6
        end
      end
    end
  end

  // memory limits, stored the same way as the bases
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        mem_limit_q[i] <= cbwd_pkg::RST_MEM_FIELD;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cfg.wr && sel_mem_limit[i]) begin
          mem_limit_q[i] <= mem_limit_wr[i][31:cbwd_pkg::MEM_ADDR_LSB]; // R6
        end
      end
    end
  end

  // io bases; page and select bits are not stored, so writes cannot move them
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        io_base_q[i] <= cbwd_pkg::RST_IO_FIELD;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cfg.wr && sel_io_base[i]) begin
          io_base_q[i] <= io_base_wr[i][cbwd_pkg::IO_ADDR_MSB:cbwd_pkg::IO_ADDR_LSB]; // R12
        end
      end
    end
  end

  // io limits; read-only bits are rebuilt on readback, never stored
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        io_limit_q[i] <= cbwd_pkg::RST_IO_FIELD;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cfg.wr && sel_io_limit[i]) begin
          io_limit_q[i] <= io_limit_wr[i][cbwd_pkg::IO_ADDR_MSB:cbwd_pkg::IO_ADDR_LSB]; // R14 R16
        end
      end
    end
  end

  // read mux; unmapped offsets answer zero
  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = 32'h00000000;
    unique case (dw_addr)
      cbwd_pkg::OFF_PRIMARY_BUS:    rdata_d = bus_dw_old;
      cbwd_pkg::OFF_MEM_WIN0_BASE:  rdata_d = mem_word(mem_base_q[0]);
      cbwd_pkg::OFF_MEM_WIN0_LIMIT: rdata_d = mem_word(mem_limit_q[0]);
      cbwd_pkg::OFF_MEM_WIN1_BASE:  rdata_d = mem_word(mem_base_q[1]);
      cbwd_pkg::OFF_MEM_WIN1_LIMIT: rdata_d = mem_word(mem_limit_q[1]);
      cbwd_pkg::OFF_IO_WIN0_BASE:   rdata_d = io_word(io_base_q[0], io_base_sel);
      cbwd_pkg::OFF_IO_WIN0_LIMIT:  rdata_d = io_word(io_limit_q[0], io_limit_sel);
      cbwd_pkg::OFF_IO_WIN1_BASE:   rdata_d = io_word(io_base_q[1], io_base_sel);
      cbwd_pkg::OFF_IO_WIN1_LIMIT:  rdata_d = io_word(io_limit_q[1], io_limit_sel);
      default:                      rdata_d = 32'h00000000;
    endcase
  end

  // read answer one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_rdata  <= 32'h00000000;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg.rd;
      if (cfg.rd) begin
        cfg_rdata <= rdata_d;
      end
    end
  end

  // window hit test for one request; returns per-window mem and io hits
  function automatic logic [3:0] win_hits(input cbwd_pkg::cbwd_req_type r,
                                          input logic [19:0] mb0, input logic [19:0] ml0,
                                          input logic [19:0] mb1, input logic [19:0] ml1,
                                          input logic [13:0] ib0, input logic [13:0] il0,
                                          input logic [13:0] ib1, input logic [13:0] il1);
    logic [3:0] h;
    logic       page0;
    page0 = (r.addr[31:16] == 16'h0000); // R11
    h[0] = r.is_mem && ((mb0 | ml0) != 20'h00000) // R9
           && ({r.addr[31:12], 12'h000} >= {mb0, 12'h000})
           && (r.addr <= {ml0, cbwd_pkg::MEM_LOW_FILL}); // R20
    h[1] = r.is_mem && ((mb1 | ml1) != 20'h00000) // R9
           && ({r.addr[31:12], 12'h000} >= {mb1, 12'h000})
           && (r.addr <= {ml1, cbwd_pkg::MEM_LOW_FILL}); // R20
    h[2] = r.is_io && page0 && ((ib0 | il0) != 14'h0000) // R17
           && (r.addr[15:2] >= ib0) && (r.addr[15:2] <= il0); // R20
    h[3] = r.is_io && page0 && ((ib1 | il1) != 14'h0000) // R17
           && (r.addr[15:2] >= ib1) && (r.addr[15:2] <= il1); // R20
    return h;
  endfunction : win_hits

  logic [3:0] pri_hits;
  logic [3:0] sec_hits;
  assign pri_hits = win_hits(pri_req, mem_base_q[0], mem_limit_q[0], mem_base_q[1], mem_limit_q[1],
                             io_base_q[0], io_limit_q[0], io_base_q[1], io_limit_q[1]);
  assign sec_hits = win_hits(sec_req, mem_base_q[0], mem_limit_q[0], mem_base_q[1], mem_limit_q[1],
                             io_base_q[0], io_limit_q[0], io_base_q[1], io_limit_q[1]);

  // registered decode answers; one cycle behind the request
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pri_claim      <= 1'b0;
      pri_prefetch   <= 1'b0;
      pri_window_hit <= 2'b00;
    end else begin
      pri_claim      <= |pri_hits; // R8 R18
      pri_prefetch   <= (pri_hits[0] && mem_window0_prefetchable)
                        || (pri_hits[1] && mem_window1_prefetchable); // R10
      pri_window_hit <= {pri_hits[1] | pri_hits[3], pri_hits[0] | pri_hits[2]};
    end
  end

  // card cycles outside every window belong upstream
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sec_forward <= 1'b0;
    end else begin
      sec_forward <= (sec_req.is_mem || sec_req.is_io) && !(|sec_hits); // R8 R18
    end
  end

  // configuration cycle routing by bus number
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_to_primary       <= 1'b0;
      cfg_to_secondary     <= 1'b0;
      cfg_beyond_secondary <= 1'b0;
    end else begin
      cfg_to_primary       <= cfg_cycle_valid && (cfg_cycle_bus == primary_bus_q); // R19
      cfg_to_secondary     <= cfg_cycle_valid && (cfg_cycle_bus == secondary_bus_q); // R1 R21
      cfg_beyond_secondary <= cfg_cycle_valid && (cfg_cycle_bus > secondary_bus_q)
                              && (cfg_cycle_bus <= subordinate_bus_q); // R2 R21
    end
  end

  // link clock enable from a free-running divider
  localparam int DIV_W = (CCLK_DIV > 1) ? $clog2(CCLK_DIV) : 1;
  logic [DIV_W-1:0] div_q;
  logic             cclk_en;
  assign cclk_en = (div_q == DIV_W'(CCLK_DIV - 1));

  always_ff @(posedge ref_clk) begin
    if (rst || cclk_en) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DIV_W'(1);
    end
  end

  // latency timer; a zero setting expires at once
  logic [7:0] lat_cnt_q;
  logic       lat_active_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lat_cnt_q    <= cbwd_pkg::RST_LATENCY;
      lat_active_q <= 1'b0;
    end else if (init_frame_start) begin
      lat_cnt_q    <= latency_q; // R3
      lat_active_q <= 1'b1;
    end else if (init_xfer_end || init_last_phase) begin
      lat_active_q <= 1'b0;
    end else if (lat_active_q && cclk_en && lat_cnt_q != 8'h00) begin
      lat_cnt_q <= lat_cnt_q - 8'h01; // R3
    end
  end

  assign lat_expired     = lat_active_q && (lat_cnt_q == 8'h00);
  // handshake term: the data phase completing now must be the last one
  assign init_last_phase = lat_expired && init_data_done; // R4

endmodule : cbwd_decode

// ### rtl/cbwd_pkg.sv
// constants and carrier types for the bridge window and bus-number decode
package cbwd_pkg;

  // configuration offsets (byte addresses)
  localparam logic [7:0] OFF_PRIMARY_BUS     = 8'h18;
  localparam logic [7:0] OFF_SECONDARY_BUS   = 8'h19;
  localparam logic [7:0] OFF_SUBORDINATE_BUS = 8'h1a;
  localparam logic [7:0] OFF_SEC_LATENCY     = 8'h1b;
  localparam logic [7:0] OFF_MEM_WIN0_BASE   = 8'h1c;
  localparam logic [7:0] OFF_MEM_WIN0_LIMIT  = 8'h20;
  localparam logic [7:0] OFF_MEM_WIN1_BASE   = 8'h24;
  localparam logic [7:0] OFF_MEM_WIN1_LIMIT  = 8'h28;
  localparam logic [7:0] OFF_IO_WIN0_BASE    = 8'h2c;
  localparam logic [7:0] OFF_IO_WIN0_LIMIT   = 8'h30;
  localparam logic [7:0] OFF_IO_WIN1_BASE    = 8'h34;
  localparam logic [7:0] OFF_IO_WIN1_LIMIT   = 8'h38;
  localparam logic [7:0] OFF_WIN_STRIDE      = 8'h08;

  // field positions
  localparam int MEM_ADDR_LSB = 12;
  localparam int IO_ADDR_LSB  = 2;
  localparam int IO_ADDR_MSB  = 15;
  localparam int IO_PAGE_LSB  = 16;

  // reset values
  localparam logic [7:0]  RST_BUS_NUMBER  = 8'h00;
  localparam logic [7:0]  RST_LATENCY     = 8'h00;
  localparam logic [19:0] RST_MEM_FIELD   = 20'h00000;
  localparam logic [13:0] RST_IO_FIELD    = 14'h0000;

  // low bits of io registers as selected by the general control bits, and the low fill patterns of io and memory limits
  localparam logic [1:0]  IO_LOW_SEL_CLR  = 2'b00;
  localparam logic [1:0]  IO_LOW_SEL_SET  = 2'b01;
  localparam logic [1:0]  IO_LOW_FILL     = 2'b11;
  localparam logic [11:0] MEM_LOW_FILL    = 12'hfff;

  // link clock rate derived from the core clock
  localparam int REF_CLK_MHZ  = 100;
  localparam int CCLK_MHZ     = 33;
  localparam int CCLK_DIV     = REF_CLK_MHZ / CCLK_MHZ;

  // one address decode request
  typedef struct packed {
    logic [31:0] addr;
    logic        is_mem;
    logic        is_io;
  } cbwd_req_type;

  // configuration access from the primary side
  typedef struct packed {
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cbwd_cfg_type;

endpackage : cbwd_pkg

// ### verif/cardbus_window_decode_tb.sv
// self-checking bench for the window and bus-number decode
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_total++; $display("[ERR] %s exp=%0h got=%0h", nm, ex, got); end end
module cardbus_window_decode_tb;
  typedef struct packed { logic [7:0] a; logic [31:0] rst_v; logic [31:0] wd; logic [31:0] rd_v; } cbwd_row_type;
  typedef struct packed { logic [31:0] a; logic m; logic [3:0] ex; } cbwd_dec_type;
  logic                   ref_clk, rst, pf0, pf1, base_sel, limit_sel, cyc_valid, go;
  logic                   cfg_rvalid, to_pri, to_sec, beyond, claim, pfetch, fwd, lat_exp, last_ph, fstart, ddone, xend, busy;
  logic [7:0]             cyc_bus, max_ph, phases;
  logic [1:0]             hit;
  logic [31:0]            cfg_rdata;
  cbwd_pkg::cbwd_cfg_type cfg;
  cbwd_pkg::cbwd_req_type req;
  int                     err_total, checked, i;
  // one write and read-back per register except the io window 1 limit, then unmapped 3ch; io base low bits follow base_sel = 1
  cbwd_row_type rows [9] = '{'{8'h18, 32'h0, 32'h0806_0201, 32'h0806_0201}, '{8'h1c, 32'h0, 32'h1234_5fff, 32'h1234_5000},
    '{8'h20, 32'h0, 32'h1234_7abc, 32'h1234_7000}, '{8'h24, 32'h0, 32'hffff_f123, 32'hffff_f000},
    '{8'h28, 32'h0, 32'hffff_ffff, 32'hffff_f000}, '{8'h2c, 32'h1, 32'hffff_1237, 32'h0000_1235},
    '{8'h30, 32'h0, 32'hffff_13ff, 32'h0000_13fc}, '{8'h34, 32'h1, 32'h0, 32'h1}, '{8'h3c, 32'h0, 32'hffff_ffff, 32'h0}};
  // decode cases around both edges of memory window 0 and at the io window 0 edges; ex = {claim, hit, prefetch}
  cbwd_dec_type decs [10] = '{'{32'h1234_4fff, 1'b1, 4'h0}, '{32'h1234_5000, 1'b1, 4'hb}, '{32'h1234_7fff, 1'b1, 4'hb},
    '{32'h1234_8000, 1'b1, 4'h0}, '{32'hffff_ffff, 1'b1, 4'hc}, '{32'h0000_1234, 1'b0, 4'ha},
    '{32'h0000_1233, 1'b0, 4'h0}, '{32'h0000_13ff, 1'b0, 4'ha}, '{32'h0001_1234, 1'b0, 4'h0}, '{32'h0, 1'b0, 4'h0}};
  logic [7:0] buses [6] = '{8'h05, 8'h06, 8'h10, 8'h11, 8'h04, 8'h01};
  logic [2:0] routes [6] = '{3'b010, 3'b001, 3'b001, 3'b000, 3'b000, 3'b100};

  cbwd_decode #(.CCLK_DIV(3)) u_dut (.ref_clk(ref_clk), .rst(rst), .cfg(cfg), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .mem_window0_prefetchable(pf0), .mem_window1_prefetchable(pf1), .io_base_sel(base_sel),
    .io_limit_sel(limit_sel), .cfg_cycle_valid(cyc_valid), .cfg_cycle_bus(cyc_bus), .cfg_to_primary(to_pri),
    .cfg_to_secondary(to_sec), .cfg_beyond_secondary(beyond), .pri_req(req), .pri_claim(claim), .pri_prefetch(pfetch),
    .pri_window_hit(hit), .sec_req(req), .sec_forward(fwd), .init_frame_start(fstart), .init_data_done(ddone),
    .init_xfer_end(xend), .lat_expired(lat_exp), .init_last_phase(last_ph));
  cbwd_card_model u_card (.ref_clk(ref_clk), .rst(rst), .go(go), .init_last_phase(last_ph), .max_phases(max_ph),
    .init_frame_start(fstart), .init_data_done(ddone), .init_xfer_end(xend), .busy(busy), .phases(phases));

  // free-running core clock
  always #5 ref_clk = ~ref_clk;

  task automatic finish_test();
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  // one config access, held for exactly one clock edge
  task automatic cfg_acc(input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd, input logic wr);
    @(negedge ref_clk);
    cfg = '{addr: a, be: be, wdata: wd, wr: wr, rd: !wr};
    @(negedge ref_clk);
    cfg = '0;
  endtask : cfg_acc
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex);
    cfg_acc(a, 4'hf, 32'h0, 1'b0);
    `CHK("rvalid", 1'b1, cfg_rvalid)
    `CHK("rdata", ex, cfg_rdata)
  endtask : rd_chk
  // same request on both sides: a miss on a typed cycle means upstream forward
  task automatic dec_chk(input cbwd_dec_type d);
    @(negedge ref_clk);
    req = '{addr: d.a, is_mem: d.m, is_io: !d.m};
    @(negedge ref_clk);
    `CHK("claim", d.ex, {claim, hit, pfetch})
    `CHK("forward", !d.ex[3], fwd)
  endtask : dec_chk
  task automatic card_run(input logic [7:0] lat, input logic [7:0] mx);
    cfg_acc(8'h18, 4'b1000, {lat, 24'h0}, 1'b1);
    max_ph = mx;
    @(negedge ref_clk) go = 1'b1;
    @(negedge ref_clk) go = 1'b0;
    for (i = 0; i < 500 && busy; i++) @(negedge ref_clk);
    `CHK("card_busy", 1'b0, busy)
    `CHK("lat_expired", 1'b0, lat_exp)
  endtask : card_run

  // watchdog, far beyond the fewer than 200 cycles the sequence needs
  initial begin
    #200_000;
    err_total++;
    finish_test();
  end
  // main sequence
  initial begin
    {ref_clk, rst, pf0, pf1, base_sel, limit_sel, cyc_valid, go, cyc_bus, max_ph, cfg, req} = '0;
    rst = 1'b1;
    pf0 = 1'b1;
    base_sel = 1'b1;
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    dec_chk('{32'h0, 1'b1, 4'h0});
    dec_chk('{32'h0, 1'b0, 4'h0});
    for (int r = 0; r < 9; r++) begin
      rd_chk(rows[r].a, rows[r].rst_v);
      cfg_acc(rows[r].a, 4'hf, rows[r].wd, 1'b1);
      rd_chk(rows[r].a, rows[r].rd_v);
    end
    for (int r = 0; r < 10; r++) dec_chk(decs[r]);
    cfg_acc(8'h18, 4'b0110, 32'h0010_0500, 1'b1);
    rd_chk(8'h18, 32'h0810_0501);
    cyc_valid = 1'b1;
    for (int r = 0; r < 6; r++) begin
      cyc_bus = buses[r];
      @(negedge ref_clk);
      @(negedge ref_clk);
      `CHK("route", routes[r], {to_pri, to_sec, beyond})
    end
    base_sel = 1'b0;
    limit_sel = 1'b1;
    rd_chk(8'h2c, 32'h0000_1234);
    rd_chk(8'h30, 32'h0000_13fd);
    card_run(8'h00, 8'h10);
    `CHK("phases", 8'h01, phases)
    card_run(8'h08, 8'h20);
    `CHK("phases", 1'b1, (phases >= 8'h06 && phases <= 8'h08))
    card_run(8'h20, 8'h04);
    `CHK("phases", 8'h04, phases)
    // reset in mid-run clears bus numbers and shuts the open windows
    rst = 1'b1;
    @(negedge ref_clk) rst = 1'b0;
    rd_chk(8'h18, 32'h0);
    rd_chk(8'h1c, 32'h0);
    dec_chk('{32'h1234_5000, 1'b1, 4'h0});
    finish_test();
  end
endmodule : cardbus_window_decode_tb

// ### verif/cbwd_card_model.sv
// card-side transaction model that answers data phases to the bridge initiator
`timescale 1ns/1ps
module cbwd_card_model (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       go,
  input  wire logic       init_last_phase,
  input  wire logic [7:0] max_phases,
  output logic            init_frame_start,
  output logic            init_data_done,
  output logic            init_xfer_end,
  output logic            busy,
  output logic [7:0]      phases
);
  logic [1:0] gap_q;
  // one data phase every four cycles, slow enough for the timer to run out
  always_ff @(posedge ref_clk) begin
    init_frame_start <= 1'b0;
    init_data_done   <= 1'b0;
    init_xfer_end    <= 1'b0;
    if (rst) begin
      busy   <= 1'b0;
      phases <= 8'h00;
      gap_q  <= 2'h0;
    end else if (go && !busy) begin
      busy             <= 1'b1;
      phases           <= 8'h00;
      gap_q            <= 2'h0;
      init_frame_start <= 1'b1;
    end else if (busy) begin
      // stop after the phase flagged last, or when the burst is used up
      if (init_data_done && (init_last_phase || phases == max_phases)) begin
        busy          <= 1'b0;
        init_xfer_end <= 1'b1;
      end else begin
        gap_q <= gap_q + 2'h1;
        if (gap_q == 2'h3) begin
          init_data_done <= 1'b1;
          phases         <= phases + 8'h01;
        end
      end
    end
  end
endmodule : cbwd_card_model

// ### verif/cbwd_decode_props.sv
// assertion checker for the window and bus-number decode
`timescale 1ns/1ps
module cbwd_decode_props #(
  parameter int CCLK_DIV = 3
) (
  input wire logic                   ref_clk, rst, cfg_rvalid, io_base_sel, io_limit_sel, cfg_cycle_valid,
  input wire cbwd_pkg::cbwd_cfg_type cfg,
  input wire logic [31:0]            cfg_rdata,
  input wire logic                   cfg_to_secondary, cfg_beyond_secondary, pri_claim, pri_prefetch,
  input wire cbwd_pkg::cbwd_req_type pri_req,
  input wire logic [1:0]             pri_window_hit,
  input wire logic                   lat_expired, init_data_done, init_last_phase, init_frame_start
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // read port answers exactly one cycle after the request
  a_rvalid_after_rd: assert property (cfg.rd |=> cfg_rvalid) else $error("read not answered");
  a_rvalid_has_cause: assert property (cfg_rvalid |-> $past(cfg.rd)) else $error("stray read valid");
  // loose bits of memory and io registers
  a_mem_low_zero: assert property (cfg_rvalid && $past(cfg.addr[7:2]) inside {6'h07, 6'h08, 6'h09, 6'h0a}
    |-> cfg_rdata[11:0] == 12'h000) else $error("memory low bits not zero");
  a_io_page_zero: assert property (cfg_rvalid && $past(cfg.addr[7:2]) inside {6'h0b, 6'h0c, 6'h0d, 6'h0e}
    |-> cfg_rdata[31:16] == 16'h0000) else $error("io upper half not zero");
  a_io_base_low: assert property (cfg_rvalid && $past(cfg.addr[7:2]) inside {6'h0b, 6'h0d}
    |-> cfg_rdata[1:0] == {1'b0, $past(io_base_sel)}) else $error("io base low bits wrong");
  a_io_limit_low: assert property (cfg_rvalid && $past(cfg.addr[7:2]) inside {6'h0c, 6'h0e}
    |-> cfg_rdata[1:0] == {1'b0, $past(io_limit_sel)}) else $error("io limit low bits wrong");
  // routing and claims follow their request one cycle earlier
  a_route_exclusive: assert property (cfg_to_secondary |-> !cfg_beyond_secondary && $past(cfg_cycle_valid))
    else $error("config route conflict");
  a_claim_has_hit: assert property (pri_claim |-> $past(pri_req.is_mem || pri_req.is_io)
    && pri_window_hit != 2'b00) else $error("claim without hit");
  a_io_claim_page: assert property (pri_claim && $past(pri_req.is_io) |-> $past(pri_req.addr[31:16]) == 16'h0000)
    else $error("io claim outside first page");
  a_prefetch_mem: assert property (pri_prefetch |-> pri_claim && $past(pri_req.is_mem)) else $error("bad prefetch");
  a_last_phase: assert property (init_last_phase == (lat_expired && init_data_done)) else $error("last phase wrong");
  a_timer_stop: assert property (init_last_phase && !init_frame_start |=> !lat_expired)
    else $error("timer still expired after last phase");
  c_last_phase: cover property (init_last_phase);
  c_win1_hit: cover property (pri_claim && pri_window_hit == 2'b10);
  c_beyond: cover property (cfg_beyond_secondary);
endmodule : cbwd_decode_props
bind cbwd_decode cbwd_decode_props #(.CCLK_DIV(CCLK_DIV)) u_props (.ref_clk(ref_clk), .rst(rst),
  .cfg_rvalid(cfg_rvalid), .io_base_sel(io_base_sel), .io_limit_sel(io_limit_sel), .cfg_cycle_valid(cfg_cycle_valid),
  .cfg(cfg), .cfg_rdata(cfg_rdata), .cfg_to_secondary(cfg_to_secondary), .cfg_beyond_secondary(cfg_beyond_secondary),
  .pri_claim(pri_claim), .pri_prefetch(pri_prefetch), .pri_req(pri_req), .pri_window_hit(pri_window_hit),
  .lat_expired(lat_expired), .init_data_done(init_data_done), .init_last_phase(init_last_phase),
  .init_frame_start(init_frame_start));
